// >>> logic/sfes_defines.vh
// constants for the serial flash erase sequencer
// Behaviour
// R1: page erase frame is opcode 81h then three address bytes.
// R2: page frame bytes: don't-care, then dummy bit plus page index, then don't-care.
// R3: chip select rise ending a page frame erases the selected 256-byte page.
// R4: page erase is self-timed, bounded, and busy shows for its whole duration.
// R5: any byte failing to erase sets the erase/program error flag.
// R6: opcode 20h is 4-Kbyte block erase; 52h or D8h is 32-Kbyte.
// R7: block erase starts only with the write enable latch already set.
// R8: after opcode and three address bytes extra bits are ignored; erase on deselect.
// R9: 4-Kbyte erase ignores address bits 11..0; 32-Kbyte ignores bits 14..0.
// R10: block erase aborts if address incomplete or deselect off a byte boundary.
// R11: protected memory: block erase not executed, idle after deselect.
// R12: block erase abort for any cause clears the write enable latch.
// R13: successful erase shows busy and clears the latch before completion.
// R14: host should poll status rather than wait the full erase time.
// R15: 60h, 62h, C7h all mean chip erase, no address, extra bits ignored.
// R16: chip erase starts only on full opcode and byte-aligned deselect.
// R17: protected array: chip erase not executed, idle after deselect.
// R18: chip erase off byte boundary or protected clears the write enable latch.
// R19: chip erase starts only with the write enable latch already set.
// R20: memory is protected when the array protect bit is one.
// R21: opcode 06h sets the latch on a byte-aligned deselect.
// R22: busy ends when the erase finishes; commands ignored while busy.
`ifndef SFES_DEFINES_VH
`define SFES_DEFINES_VH
`define SFES_OP_PAGE_ERASE   8'h81
`define SFES_OP_BLK4_ERASE   8'h20
`define SFES_OP_BLK32_ERASE_A 8'h52
`define SFES_OP_BLK32_ERASE_B 8'hd8
`define SFES_OP_CHIP_ERASE_A 8'h60
`define SFES_OP_CHIP_ERASE_B 8'h62
`define SFES_OP_CHIP_ERASE_C 8'hc7
`define SFES_OP_WRITE_ENABLE 8'h06
`define SFES_BITS_OPCODE     6'd8
`define SFES_BITS_ADDR_FRAME 6'd32
`define SFES_PAGE_INDEX_MSB  14
`define SFES_PAGE_INDEX_LSB  8
`define SFES_BLK4_KEEP_LSB   12
`define SFES_BLK32_KEEP_LSB  15
`define SFES_ADDR_TOP        14
`define SFES_CLK_NS          5
`define SFES_PAGE_ERASE_TIME_US  20000
`define SFES_BLOCK_ERASE_TIME_US 300000
`define SFES_CHIP_ERASE_TIME_US  1000000
`define SFES_KIND_PAGE       2'd0
`define SFES_KIND_BLK4       2'd1
`define SFES_KIND_BLK32      2'd2
`define SFES_KIND_CHIP       2'd3
`endif

// >>> logic/sfes_erase_timer.v
// self-timed erase duration counter for the erase sequencer
`include "sfes_defines.vh"
module sfes_erase_timer #(
    parameter [31:0] PAGE_CYCLES  = 32'd4000000,
    parameter [31:0] BLOCK_CYCLES = 32'd60000000,
    parameter [31:0] CHIP_CYCLES  = 32'd200000000
) (
    input  wire        clock_in,
    input  wire        rst_n_in,
    input  wire        start_in,
    input  wire [1:0]  kind_in,
    output reg         done_out
);
    reg [31:0] count_q;
    reg        run_q;

    // load the bound for the requested kind, count down, pulse done at one
    always @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_q  <= 32'h0;
            run_q    <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                run_q <= 1'b1;
                if (kind_in == `SFES_KIND_PAGE)
                    count_q <= PAGE_CYCLES;
                else if (kind_in == `SFES_KIND_CHIP)
                    count_q <= CHIP_CYCLES;
                else
                    count_q <= BLOCK_CYCLES;
            end else if (run_q) begin
                if (count_q <= 32'h1) begin
                    run_q    <= 1'b0;
                    done_out <= 1'b1; // R4
                end else begin
                    count_q <= count_q - 32'h1;
                end
            end
        end
    end
endmodule // sfes_erase_timer

// >>> logic/sfes_erase_sequencer.v
// serial flash erase command decoder and sequencer
`include "sfes_defines.vh"
module sfes_erase_sequencer #(
    parameter [31:0] PAGE_CYCLES  = (`SFES_PAGE_ERASE_TIME_US * 1000) / `SFES_CLK_NS,
    parameter [31:0] BLOCK_CYCLES = (`SFES_BLOCK_ERASE_TIME_US * 1000) / `SFES_CLK_NS,
    parameter [31:0] CHIP_CYCLES  = (`SFES_CHIP_ERASE_TIME_US * 1000) / `SFES_CLK_NS
) (
    input  wire        clock_in,
    input  wire        arst_n_in,
    input  wire        chip_select_n_in,
    input  wire        serial_clock_in,
    input  wire        serial_data_in,
    input  wire        array_protect_bit_in,
    input  wire        erase_fault_in,
    input  wire        clear_error_in,
    output reg         busy_out,
    output reg         write_enable_latch_out,
    output reg         erase_program_error_flag_out,
    output reg         erase_start_out,
    output reg  [1:0]  erase_kind_out,
    output reg  [14:0] erase_base_out
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ERASE = 2'd1;

    reg        rst_s1_q;
    reg        rst_n_q;
    reg [1:0]  cs_sync_q;
    reg [1:0]  sck_sync_q;
    reg [1:0]  sdi_sync_q;
    reg        sck_prev_q;
    reg        cs_prev_q;
    reg [5:0]  bit_cnt_q;
    reg        byte_odd_q;
    reg [7:0]  opcode_q;
    reg [23:0] addr_q;
    reg [1:0]  state_q;
    reg        fault_seen_q;
    wire       timer_done;

    // opcode decode helpers used only by the frame-end logic, which also sets and clears the latch
    function is_block;
        input [7:0] op;
        begin
            is_block = (op == `SFES_OP_BLK4_ERASE) || (op == `SFES_OP_BLK32_ERASE_A) ||
                       (op == `SFES_OP_BLK32_ERASE_B); // R6
        end
    endfunction

    function is_chip;
        input [7:0] op;
        begin
            is_chip = (op == `SFES_OP_CHIP_ERASE_A) || (op == `SFES_OP_CHIP_ERASE_B) ||
                      (op == `SFES_OP_CHIP_ERASE_C); // R15
        end
    endfunction

    // reset release through two flops so deassertion is synchronous
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // pins come from the host's domain; second stage only feeds logic
    always @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cs_sync_q  <= 2'b11;
            sck_sync_q <= 2'b00;
            sdi_sync_q <= 2'b00;
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else begin
            cs_sync_q  <= {cs_sync_q[0], chip_select_n_in};
            sck_sync_q <= {sck_sync_q[0], serial_clock_in};
            sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
            sck_prev_q <= sck_sync_q[1];
            cs_prev_q  <= cs_sync_q[1];
        end
    end

    wire cs_active = !cs_sync_q[1];
    wire sck_rise  = sck_sync_q[1] && !sck_prev_q;
    wire cs_rise   = cs_sync_q[1] && !cs_prev_q;
    wire cs_fall   = !cs_sync_q[1] && cs_prev_q;
    wire on_byte   = (bit_cnt_q[2:0] == 3'd0) && !byte_odd_q;
    wire opc_done  = (bit_cnt_q >= `SFES_BITS_OPCODE);
    wire addr_done = (bit_cnt_q >= `SFES_BITS_ADDR_FRAME);
    wire arr_locked = array_protect_bit_in; // R20
    wire idle      = (state_q == ST_IDLE);

    // shift opcode then address bytes msb first; later bits are ignored
    always @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bit_cnt_q  <= 6'd0;
            byte_odd_q <= 1'b0;
            opcode_q   <= 8'h00;
            addr_q     <= 24'h0;
        end else if (cs_fall) begin
            bit_cnt_q  <= 6'd0;
            byte_odd_q <= 1'b0;
        end else if (cs_active && sck_rise) begin
            if (!addr_done)
                bit_cnt_q <= bit_cnt_q + 6'd1;
            else
                byte_odd_q <= (bit_cnt_q[2:0] == 3'd7) ? 1'b0 : 1'b1;
            if (addr_done)
                bit_cnt_q <= {3'b100, bit_cnt_q[2:0] + 3'd1}; // R8
            if (!opc_done)
                opcode_q <= {opcode_q[6:0], sdi_sync_q[1]}; // R1
            else if (!addr_done)
                addr_q <= {addr_q[22:0], sdi_sync_q[1]};
        end
    end

    // frame end decides erase, abort or latch set; busy blocks every frame, not the error clear
    always @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q                      <= ST_IDLE;
            busy_out                     <= 1'b0;
            write_enable_latch_out       <= 1'b0;
            erase_program_error_flag_out <= 1'b0;
            erase_start_out              <= 1'b0;
            erase_kind_out               <= `SFES_KIND_PAGE;
            erase_base_out               <= 15'h0;
            fault_seen_q                 <= 1'b0;
        end else begin
            erase_start_out <= 1'b0;
            // clear first so a fault in the same cycle wins
            if (clear_error_in)
                erase_program_error_flag_out <= 1'b0;
            case (state_q)
            ST_IDLE: begin
                if (cs_rise) begin
                    if (opc_done && on_byte && opcode_q == `SFES_OP_WRITE_ENABLE) begin
                        write_enable_latch_out <= 1'b1; // R21
                    end else if (opcode_q == `SFES_OP_PAGE_ERASE && opc_done) begin
                        if (!addr_done || !on_byte || arr_locked) begin
                            write_enable_latch_out <= 1'b0;
                        end else if (write_enable_latch_out) begin
                            // R2: middle byte carries dummy bit and page index
                            erase_kind_out  <= `SFES_KIND_PAGE; // R3
                            erase_base_out  <= {addr_q[`SFES_PAGE_INDEX_MSB:
                                               `SFES_PAGE_INDEX_LSB], 8'h00}; // R3
                            erase_start_out <= 1'b1;
                            busy_out        <= 1'b1; // R4
                            fault_seen_q    <= 1'b0;
                            state_q         <= ST_ERASE;
                        end
                    end else if (is_block(opcode_q) && opc_done) begin
                        if (!addr_done || !on_byte || arr_locked) begin // R10 R11
                            write_enable_latch_out <= 1'b0; // R12
                        end else if (write_enable_latch_out) begin // R7
                            if (opcode_q == `SFES_OP_BLK4_ERASE) begin
                                erase_kind_out <= `SFES_KIND_BLK4;
                                erase_base_out <= {addr_q[`SFES_ADDR_TOP:
                                                  `SFES_BLK4_KEEP_LSB], 12'h000}; // R9
                            end else begin
                                erase_kind_out <= `SFES_KIND_BLK32;
                                erase_base_out <= 15'h0000; // R9
                            end
                            erase_start_out <= 1'b1; // R8
                            busy_out        <= 1'b1; // R13
                            fault_seen_q    <= 1'b0;
                            state_q         <= ST_ERASE;
                        end
                    end else if (is_chip(opcode_q) && opc_done) begin
                        if (!on_byte || arr_locked) begin // R16 R17
                            write_enable_latch_out <= 1'b0; // R18
                        end else if (write_enable_latch_out) begin // R19
                            erase_kind_out  <= `SFES_KIND_CHIP;
                            erase_base_out  <= 15'h0000;
                            erase_start_out <= 1'b1; // R16
                            busy_out        <= 1'b1; // R13
                            fault_seen_q    <= 1'b0;
                            state_q         <= ST_ERASE;
                        end
                    end
                end
            end
            ST_ERASE: begin
                // latch drops at erase start; frames are not acted on
                write_enable_latch_out <= 1'b0; // R13
                if (erase_fault_in)
                    fault_seen_q <= 1'b1;
                if (timer_done) begin
                    busy_out <= 1'b0; // R22
                    state_q  <= ST_IDLE;
                    if (fault_seen_q || erase_fault_in)
                        erase_program_error_flag_out <= 1'b1; // R5
                end
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

    // the long erase durations are parameters so simulation can shorten them
    sfes_erase_timer #(
        .PAGE_CYCLES  (PAGE_CYCLES),
        .BLOCK_CYCLES (BLOCK_CYCLES),
        .CHIP_CYCLES  (CHIP_CYCLES)
    ) u_timer (
        .clock_in (clock_in),
        .rst_n_in (rst_n_q),
        .start_in (erase_start_out),
        .kind_in  (erase_kind_out),
        .done_out (timer_done)
    );
endmodule // sfes_erase_sequencer

// >>> tb/sfes_host_model.sv
// host serial controller model: select, serial clock and data
module sfes_host_model (
    input  wire logic clock_in,
    output logic      chip_select_n_out,
    output logic      serial_clock_out,
    output logic      serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle: deselected, clock parked low between frames
    initial begin
        chip_select_n_out = 1'b1;
        serial_clock_out  = 1'b0;
        serial_data_out   = 1'b0;
    end

    // one frame msb first, 125 ns serial period; the caller picks the bit count
    task automatic frame(input logic [31:0] word, input int nbits);
        int i;
        @(negedge clock_in);
        chip_select_n_out = 1'b0;
        for (i = 0; i < nbits; i++) begin
            serial_data_out = word[31 - (i % 32)]; // bits past 32 wrap, device ignores
            repeat (12) @(negedge clock_in);
            serial_clock_out = 1'b1;
            repeat (13) @(negedge clock_in);
            serial_clock_out = 1'b0;
        end
        repeat (12) @(negedge clock_in);
        chip_select_n_out = 1'b1;
        serial_data_out   = ~serial_data_out; // released line never keeps a stale bit
        repeat (20) @(negedge clock_in);
    endtask

    // latch set command goes first, on its own frame
    task automatic write_enable(input int nbits);
        frame(32'h06000000, nbits);
    endtask
endmodule // sfes_host_model

// >>> tb/sfes_erase_checker.sv
// port assertions for the erase sequencer
module sfes_erase_checker #(
    parameter [31:0] CHIP_CYCLES = 32'd800
) (
    input wire logic        clock_in,
    input wire logic        arst_n_in,
    input wire logic        array_protect_bit_in,
    input wire logic        erase_fault_in,
    input wire logic        busy_out,
    input wire logic        write_enable_latch_out,
    input wire logic        erase_program_error_flag_out,
    input wire logic        erase_start_out,
    input wire logic [1:0]  erase_kind_out,
    input wire logic [14:0] erase_base_out
);
    // longest erase plus margin bounds every busy period
    localparam int MAXB = CHIP_CYCLES + 8;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    busy_rise_a: assert property ($rose(busy_out) |-> erase_start_out)
        else $error("busy rose without an erase start");
    start_pulse_a: assert property (erase_start_out |=> !erase_start_out)
        else $error("erase start longer than one cycle");
    busy_hold_a: assert property (erase_start_out |-> busy_out ##1 busy_out[*8])
        else $error("busy dropped early");
    busy_end_a: assert property (erase_start_out |-> ##[1:MAXB] !busy_out)
        else $error("busy never ended");
    no_restart_a: assert property (busy_out && !erase_start_out |=> !erase_start_out)
        else $error("erase started while busy");
    latch_need_a: assert property ($rose(busy_out) |-> $past(write_enable_latch_out))
        else $error("erase started without latch");
    latch_clear_a: assert property (erase_start_out |-> ##[0:2] !write_enable_latch_out)
        else $error("latch not cleared by erase");
    protect_a: assert property (erase_start_out |-> !$past(array_protect_bit_in))
        else $error("erase started while protected");
    // the flag is raised when the timed erase finishes, so allow the whole busy period
    error_set_a: assert property (busy_out && erase_fault_in |-> ##[1:MAXB] erase_program_error_flag_out)
        else $error("erase fault not flagged");
    page_base_a: assert property (erase_start_out && erase_kind_out == 2'd0 |-> erase_base_out[7:0] == 8'h00)
        else $error("page base misaligned");
    blk_base_a: assert property (erase_start_out && erase_kind_out == 2'd1 |-> erase_base_out[11:0] == 12'h000)
        else $error("block base misaligned");
    kind_hold_a: assert property (busy_out && !erase_start_out |-> $stable(erase_kind_out))
        else $error("kind changed while busy");

    // main scenarios reached
    cover property (erase_start_out && erase_kind_out == 2'd3);
    cover property (erase_start_out && erase_kind_out == 2'd0);
    cover property (erase_program_error_flag_out);
endmodule // sfes_erase_checker

bind sfes_erase_sequencer sfes_erase_checker #(.CHIP_CYCLES(CHIP_CYCLES)) sfes_erase_checker_i (
    .clock_in, .arst_n_in, .array_protect_bit_in, .erase_fault_in, .busy_out,
    .write_enable_latch_out, .erase_program_error_flag_out, .erase_start_out,
    .erase_kind_out, .erase_base_out);

// >>> tb/testbench.sv
// self-checking bench for the erase sequencer
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        protect = 1'b0;
    logic        fault = 1'b0;
    logic        clear_err = 1'b0;
    wire         cs_n;
    wire         sck;
    wire         sdi;
    wire         busy;
    wire         write_enable_latch;
    wire         err;
    wire         start;
    wire  [1:0]  kind;
    wire  [14:0] base;
    logic [1:0]  last_kind = 2'd0;
    logic [14:0] last_base = 15'h0000;
    int          starts = 0, i;
    int          failures = 0;
    int          samples_checked = 0;
    logic [7:0]  ops [7] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'h62, 8'hc7};
    logic [1:0]  kinds [7] = '{2'd0, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3, 2'd3};
    logic [14:0] bases [4] = '{15'h5a00, 15'h5000, 15'h0000, 15'h0000};
    logic [7:0]  ab_ops [3] = '{8'h20, 8'hd8, 8'h60};
    int          ab_bits [3] = '{24, 33, 12};

    // 200 MHz clock
    always #2.5 clock_in = ~clock_in;

    sfes_erase_sequencer #(.PAGE_CYCLES(32'd400), .BLOCK_CYCLES(32'd600),
        .CHIP_CYCLES(32'd800)) sfes_erase_sequencer_i (
        .clock_in                     (clock_in),
        .arst_n_in                    (arst_n_in),
        .chip_select_n_in             (cs_n),
        .serial_clock_in              (sck),
        .serial_data_in               (sdi),
        .array_protect_bit_in         (protect),
        .erase_fault_in               (fault),
        .clear_error_in               (clear_err),
        .busy_out                     (busy),
        .write_enable_latch_out       (write_enable_latch),
        .erase_program_error_flag_out (err),
        .erase_start_out              (start),
        .erase_kind_out               (kind),
        .erase_base_out               (base)
    );
    sfes_host_model host_i (
        .clock_in          (clock_in),
        .chip_select_n_out (cs_n),
        .serial_clock_out  (sck),
        .serial_data_out   (sdi)
    );

    // start pulse lasts one cycle, so catch it here
    always @(posedge clock_in) begin
        if (start === 1'b1) begin
            starts <= starts + 1;
            last_kind <= kind;
            last_base <= base;
        end
    end

    task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: %s", $time, what);
        end
    endtask

    task automatic test_done();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // poll busy rather than wait a fixed erase time
    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clock_in);
        if (n == 1000) begin
            failures++;
            $display("wrong value at %0t ns: busy stuck", $time);
            test_done();
        end
    endtask

    // erase frame at a fixed address, then count starts and check the latch
    task automatic erase(input logic [7:0] op, input int nbits, input int n_exp);
        int n0;
        n0 = starts;
        host_i.frame({op, 24'h005ab3}, nbits);
        chk(15'(starts - n0), 15'(n_exp), "erase start count");
        chk(15'(write_enable_latch), 15'h0000, "latch after erase frame");
        wait_idle();
    endtask

    // main sequence
    initial begin
        repeat (5) @(negedge clock_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clock_in);
        chk({busy, write_enable_latch, err}, 15'h0000, "reset state");
        erase(8'h60, 8, 0);
        host_i.write_enable(7);
        chk(15'(write_enable_latch), 15'h0000, "latch set off boundary");
        host_i.write_enable(16);
        chk(15'(write_enable_latch), 15'h0001, "latch set");
        for (i = 0; i < 7; i++) begin
            host_i.write_enable(8);
            erase(ops[i], 40, 1);
            chk(15'(last_kind), 15'(kinds[i]), "erase kind");
            if (i < 4) chk(last_base, bases[i], "erase base");
        end
        for (i = 0; i < 3; i++) begin
            host_i.write_enable(8);
            erase(ab_ops[i], ab_bits[i], 0);
        end
        protect = 1'b1;
        host_i.write_enable(8);
        erase(8'h20, 32, 0);
        host_i.write_enable(8);
        erase(8'hc7, 8, 0);
        protect = 1'b0;
        host_i.write_enable(8);
        host_i.frame(32'h81000000, 32);
        fault = 1'b1;
        @(negedge clock_in);
        fault = 1'b0;
        host_i.write_enable(8);
        chk({busy, write_enable_latch}, 15'h0002, "frame ignored while busy");
        wait_idle();
        chk(15'(err), 15'h0001, "error set after faulty erase");
        clear_err = 1'b1;
        @(negedge clock_in);
        clear_err = 1'b0;
        @(negedge clock_in);
        chk(15'(err), 15'h0000, "error clear");
        test_done();
    end
endmodule // testbench
